// ===== logic/sss_pkg.sv
// Package: constants and types for the supply supervisor sleep control block
package sss_pkg;
	localparam int unsigned CLK_MHZ        = 50;
	localparam int unsigned OVERSHOOT_NS   = 6000;
	localparam int unsigned SHORT_MASK_NS  = 2000;
	localparam int unsigned LONG_MASK_NS   = 150000;
	localparam int unsigned ENTRY_GUARD_NS = 1000;
	localparam int unsigned OVERSHOOT_CYC  = (OVERSHOOT_NS * CLK_MHZ) / 1000;
	localparam int unsigned SHORT_MASK_CYC =
		(SHORT_MASK_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned LONG_MASK_CYC  =
		(LONG_MASK_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned ENTRY_GUARD_CYC =
		(ENTRY_GUARD_NS * CLK_MHZ) / 1000;
	localparam int unsigned CNT_W          = 14;
	localparam logic [1:0]  UNIT_OFF       = 2'h0;
	localparam logic [1:0]  UNIT_NORMAL    = 2'h1;
	localparam logic [1:0]  UNIT_FULL      = 2'h2;
	localparam logic        FLAG_RST       = 1'b0;

	typedef enum logic [1:0] {
		SSS_ACTIVE,
		SSS_LIGHT,
		SSS_DEEP
	} sss_pmode_t;

	typedef enum {
		SSS_ST_IDLE,
		SSS_ST_WAIT
	} sss_mask_st_t;
endpackage : sss_pkg

// ===== logic/sss_settle_mask.sv
// Settling-delay counter: pending flag and comparator result mask
module sss_settle_mask
	import sss_pkg::*;
(
	// Clock and reset
	input  wire logic i_mclk,
	input  wire logic i_resetn,
	// Control
	input  wire logic i_start,
	input  wire logic i_short,
	// Status
	output logic      o_pending
);
	sss_mask_st_t     state_r;
	logic [CNT_W-1:0] cnt_r;
	wire  [CNT_W-1:0] load_val = i_short ? CNT_W'(SHORT_MASK_CYC - 1)
		: CNT_W'(LONG_MASK_CYC - 1);
	wire              done     = (state_r == SSS_ST_WAIT) && (cnt_r == '0);

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_r <= SSS_ST_IDLE;
			cnt_r   <= '0;
		end else if (i_start) begin
			state_r <= SSS_ST_WAIT;
			cnt_r   <= load_val;
		end else begin
			case (state_r)
				SSS_ST_IDLE: state_r <= SSS_ST_IDLE;
				SSS_ST_WAIT: begin
					if (done) begin
						state_r <= SSS_ST_IDLE;
					end
					cnt_r <= cnt_r - CNT_W'(1);
				end
				default: state_r <= SSS_ST_IDLE;
			endcase
		end
	end

	// Restart wins over expiry so a fresh write is never lost
	assign o_pending = (state_r == SSS_ST_WAIT);

	a_pend_after_start: assert property (@(posedge i_mclk)
		disable iff (!i_resetn) i_start |=> o_pending)
		else $error("pending flag not set after start");
	a_short_expiry: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		(i_start && i_short) ##1 (!i_start)[*8] |-> o_pending)
		else $error("short mask ended too early");
	c_settle_done: cover property (@(posedge i_mclk)
		disable iff (!i_resetn) $fell(o_pending));
endmodule // sss_settle_mask

// ===== logic/sss_supply_supervisor.sv
// Top: supervisor/monitor mode decode, settling masks, wake control; clock gate enable tied high
module sss_supply_supervisor
	import sss_pkg::*;
(
	// Clock and resets
	input  wire logic       i_mclk,
	input  wire logic       i_resetn,
	input  wire logic       i_soft_reset,
	// Power mode
	input  wire logic [1:0] i_pmode,
	input  wire logic       i_sub_clk_from_osc,
	input  wire logic       i_wake_irq,
	// Low side control register fields
	input  wire logic       i_low_ctl_write,
	input  wire logic       i_low_supervisor_enable,
	input  wire logic       i_low_supervisor_sleep_keep,
	input  wire logic       i_low_supervisor_fast_perf,
	input  wire logic       i_low_monitor_enable,
	input  wire logic       i_low_monitor_fast_perf,
	input  wire logic       i_low_side_auto_control,
	// High side control register fields
	input  wire logic       i_high_ctl_write,
	input  wire logic       i_high_supervisor_enable,
	input  wire logic       i_high_supervisor_sleep_keep,
	input  wire logic       i_high_supervisor_fast_perf,
	input  wire logic       i_high_monitor_enable,
	input  wire logic       i_high_monitor_fast_perf,
	input  wire logic       i_high_side_auto_control,
	input  wire logic       i_overvoltage_guard_enable,
	// Comparator results and event routing
	input  wire logic       i_low_sup_trip,
	input  wire logic       i_low_mon_trip,
	input  wire logic       i_high_mon_trip,
	input  wire logic       i_low_event_por_sel,
	// Unit states
	output logic [1:0]      o_low_supervisor_state,
	output logic [1:0]      o_low_monitor_state,
	output logic [1:0]      o_high_supervisor_state,
	output logic [1:0]      o_high_monitor_state,
	// Status and actions
	output logic            o_low_settle_pending_flag,
	output logic            o_high_settle_pending_flag,
	output logic            o_slow_wakeup,
	output logic            o_sub_clk_gate_en,
	output logic            o_por_req,
	output logic            o_low_event_irq,
	output logic            o_wake
);
	// Supervisor decode shared by both sides
	function automatic logic [1:0] sup_dec(input logic en, input logic keep,
		input logic fp, input logic aut, input logic deep);
		logic [1:0] act;
		act = fp ? UNIT_FULL : UNIT_NORMAL;
		if (!en) sup_dec = UNIT_OFF;
		else if (!deep) sup_dec = act;
		else if (!keep) sup_dec = UNIT_OFF;
		else if (!aut) sup_dec = act;
		else sup_dec = fp ? UNIT_NORMAL : UNIT_OFF;
	endfunction

	// Monitor decode: automatic control steps down one level in deep sleep
	function automatic logic [1:0] mon_dec(input logic en, input logic fp,
		input logic aut, input logic deep);
		logic [1:0] act;
		act = fp ? UNIT_FULL : UNIT_NORMAL;
		if (!en) mon_dec = UNIT_OFF;
		else if (!deep || !aut) mon_dec = act;
		else mon_dec = fp ? UNIT_NORMAL : UNIT_OFF;
	endfunction

	wire deep = (i_pmode == SSS_DEEP);
	wire rst_n_int = i_resetn;

	wire [1:0] low_sup_nxt = sup_dec(i_low_supervisor_enable,
		i_low_supervisor_sleep_keep, i_low_supervisor_fast_perf,
		i_low_side_auto_control, deep);
	wire [1:0] low_mon_nxt = mon_dec(i_low_monitor_enable,
		i_low_monitor_fast_perf, i_low_side_auto_control, deep);
	wire [1:0] high_sup_nxt = sup_dec(i_high_supervisor_enable,
		i_high_supervisor_sleep_keep, i_high_supervisor_fast_perf,
		i_high_side_auto_control, deep);
	// Automatic high side keeps the monitor fully off in deep sleep, so the
	// overvoltage guard cannot trip on the wake-up transient
	wire high_mon_auto_off = deep && i_high_side_auto_control;
	wire [1:0] high_mon_dec = mon_dec(i_high_monitor_enable,
		i_high_monitor_fast_perf, i_high_side_auto_control, deep);
	wire [1:0] high_mon_nxt = high_mon_auto_off ? UNIT_OFF : high_mon_dec;

	wire low_sup_normal = i_low_supervisor_enable
		&& !i_low_supervisor_fast_perf;
	wire low_mon_normal = i_low_monitor_enable && !i_low_monitor_fast_perf;
	wire slow_nxt = low_sup_normal || low_mon_normal;

	logic [1:0] low_sup_r;
	logic [1:0] low_mon_r;
	logic [1:0] high_sup_r;
	logic [1:0] high_mon_r;
	logic       slow_r;
	logic       deep_r;
	logic       por_r;
	logic       irq_r;
	logic       sleep_ok_r;
	logic [8:0] ovs_cnt_r;
	logic [5:0] entry_cnt_r;

	always_ff @(posedge i_mclk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			low_sup_r  <= UNIT_OFF;
			low_mon_r  <= UNIT_OFF;
			high_sup_r <= UNIT_OFF;
			high_mon_r <= UNIT_OFF;
			slow_r     <= FLAG_RST;
			deep_r     <= FLAG_RST;
		end else begin
			low_sup_r  <= low_sup_nxt;
			low_mon_r  <= low_mon_nxt;
			high_sup_r <= high_sup_nxt;
			high_mon_r <= high_mon_nxt;
			slow_r     <= slow_nxt;
			deep_r     <= deep;
		end
	end

	// Re-enable of a comparator restarts its settle mask
	wire low_reen = (low_sup_r == UNIT_OFF && low_sup_nxt != UNIT_OFF)
		|| (low_mon_r == UNIT_OFF && low_mon_nxt != UNIT_OFF);
	wire high_reen = (high_sup_r == UNIT_OFF && high_sup_nxt != UNIT_OFF)
		|| (high_mon_r == UNIT_OFF && high_mon_nxt != UNIT_OFF);
	wire low_short = i_low_supervisor_fast_perf;
	wire high_short = i_high_supervisor_fast_perf;

	sss_settle_mask u_low_mask (
		.i_mclk    (i_mclk),
		.i_resetn  (i_resetn),
		.i_start   (i_low_ctl_write || low_reen),
		.i_short   (low_short),
		.o_pending (o_low_settle_pending_flag)
	);

	sss_settle_mask u_high_mask (
		.i_mclk    (i_mclk),
		.i_resetn  (i_resetn),
		.i_start   (i_high_ctl_write || high_reen),
		.i_short   (high_short),
		.o_pending (o_high_settle_pending_flag)
	);

	// Comparator results count only once settled
	wire low_event = !o_low_settle_pending_flag &&
		((i_low_sup_trip && low_sup_r != UNIT_OFF)
		|| (i_low_mon_trip && low_mon_r != UNIT_OFF));
	wire ovp_trip = i_overvoltage_guard_enable && i_high_mon_trip
		&& high_mon_r != UNIT_OFF && !o_high_settle_pending_flag;

	wire wake_exit = deep_r && !deep;
	// Oscillator only overshoots after deep sleep; the clock is never gated
	// then, which is the hazard software must plan around
	wire ovs_start = wake_exit && i_sub_clk_from_osc;
	// A wake request right after deep entry while a control write is still
	// settling can lose the wake; only a reset clears that condition
	wire wake_stuck = deep && i_wake_irq && (entry_cnt_r != '0)
		&& (o_low_settle_pending_flag || o_high_settle_pending_flag);

	always_ff @(posedge i_mclk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			por_r       <= FLAG_RST;
			irq_r       <= FLAG_RST;
			ovs_cnt_r   <= '0;
			entry_cnt_r <= '0;
			sleep_ok_r  <= 1'b1;
		end else begin
			por_r <= ovp_trip
				|| (low_event && i_low_event_por_sel);
			irq_r <= low_event && !i_low_event_por_sel;
			if (ovs_start) begin
				ovs_cnt_r <= 9'(OVERSHOOT_CYC);
			end else if (ovs_cnt_r != '0) begin
				ovs_cnt_r <= ovs_cnt_r - 9'(1);
			end
			if (i_soft_reset) begin
				sleep_ok_r  <= 1'b1;
				entry_cnt_r <= '0;
			end else begin
				if (wake_stuck) begin
					sleep_ok_r <= 1'b0;
				end
				if (deep && !deep_r) begin
					entry_cnt_r <= 6'(ENTRY_GUARD_CYC);
				end else if (entry_cnt_r != '0) begin
					entry_cnt_r <= entry_cnt_r - 6'(1);
				end
			end
		end
	end

	assign o_low_supervisor_state  = low_sup_r;
	assign o_low_monitor_state     = low_mon_r;
	assign o_high_supervisor_state = high_sup_r;
	assign o_high_monitor_state    = high_mon_r;
	assign o_slow_wakeup           = slow_r;
	assign o_sub_clk_gate_en       = 1'b1;
	assign o_por_req               = por_r;
	assign o_low_event_irq         = irq_r;
	assign o_wake                  = i_wake_irq && deep && sleep_ok_r;

	a_low_sup_off: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		!i_low_supervisor_enable |=> o_low_supervisor_state == UNIT_OFF)
		else $error("disabled low supervisor not off");
	a_low_auto_deep: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		(deep && i_low_side_auto_control && !i_low_supervisor_fast_perf)
		|=> o_low_supervisor_state == UNIT_OFF)
		else $error("auto low supervisor not off in deep sleep");
	a_low_mon_auto: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		(deep && i_low_side_auto_control && i_low_monitor_enable
		&& i_low_monitor_fast_perf)
		|=> o_low_monitor_state == UNIT_NORMAL)
		else $error("auto low monitor not stepped down");
	a_high_mon_auto: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		(deep && i_high_side_auto_control)
		|=> o_high_monitor_state == UNIT_OFF)
		else $error("auto high monitor active in deep sleep");
	a_high_sup_keep: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		(deep && i_high_supervisor_enable && !i_high_supervisor_sleep_keep)
		|=> o_high_supervisor_state == UNIT_OFF)
		else $error("high supervisor not off in deep sleep");
	a_ovp_por: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		ovp_trip |=> o_por_req)
		else $error("overvoltage trip without reset");
	a_slow_wake: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		(i_low_monitor_enable && !i_low_monitor_fast_perf)
		|=> o_slow_wakeup)
		else $error("slow wake-up not selected");
	a_event_route: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		low_event |=> (o_por_req || o_low_event_irq)
		&& !(o_low_event_irq && $past(i_low_event_por_sel)))
		else $error("low event misrouted");
	a_clock_ungated: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		(ovs_start || ovs_cnt_r != '0) |-> o_sub_clk_gate_en)
		else $error("subsystem clock gated during overshoot");
	a_wake_blocked: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		(wake_stuck && !i_soft_reset) |=> !sleep_ok_r)
		else $error("early wake request did not block wake");
	a_soft_recover: assert property (@(posedge i_mclk)
		disable iff (!i_resetn) i_soft_reset |=> sleep_ok_r)
		else $error("soft reset did not restore wake");

	c_deep_entry: cover property (@(posedge i_mclk) disable iff (!i_resetn)
		deep && !deep_r);
	c_wake_exit: cover property (@(posedge i_mclk) disable iff (!i_resetn)
		wake_exit);
	c_ovp: cover property (@(posedge i_mclk) disable iff (!i_resetn)
		o_por_req);
endmodule // sss_supply_supervisor

// ===== tb/sss_supply_supervisor_tb_top.sv
// Self-checking bench for the supply supervisor sleep control block
module sss_supply_supervisor_tb_top
	import sss_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic i_mclk, i_resetn, i_soft_reset, i_sub_clk_from_osc, i_wake_irq;
	logic [1:0] i_pmode;
	logic lw, lse, lsk, lsf, lme, lmf, la;
	logic hw, hse, hsk, hsf, hme, hmf, ha, overvoltage_guard;
	logic lst, lmt, hmt, psel;
	logic [1:0] o_ls, o_lm, o_hs, o_hm;
	logic o_lpend, o_hpend, o_slow, o_gate, o_por, o_irq, o_wake;
	int bad_count = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [1:0] seen;

	sss_supply_supervisor u_dut (
		.i_mclk(i_mclk), .i_resetn(i_resetn), .i_soft_reset(i_soft_reset),
		.i_pmode(i_pmode), .i_sub_clk_from_osc(i_sub_clk_from_osc),
		.i_wake_irq(i_wake_irq), .i_low_ctl_write(lw),
		.i_low_supervisor_enable(lse), .i_low_supervisor_sleep_keep(lsk),
		.i_low_supervisor_fast_perf(lsf), .i_low_monitor_enable(lme),
		.i_low_monitor_fast_perf(lmf), .i_low_side_auto_control(la),
		.i_high_ctl_write(hw), .i_high_supervisor_enable(hse),
		.i_high_supervisor_sleep_keep(hsk),
		.i_high_supervisor_fast_perf(hsf), .i_high_monitor_enable(hme),
		.i_high_monitor_fast_perf(hmf), .i_high_side_auto_control(ha),
		.i_overvoltage_guard_enable(overvoltage_guard), .i_low_sup_trip(lst),
		.i_low_mon_trip(lmt), .i_high_mon_trip(hmt),
		.i_low_event_por_sel(psel), .o_low_supervisor_state(o_ls),
		.o_low_monitor_state(o_lm), .o_high_supervisor_state(o_hs),
		.o_high_monitor_state(o_hm), .o_low_settle_pending_flag(o_lpend),
		.o_high_settle_pending_flag(o_hpend), .o_slow_wakeup(o_slow),
		.o_sub_clk_gate_en(o_gate), .o_por_req(o_por),
		.o_low_event_irq(o_irq), .o_wake(o_wake));

	initial begin
		i_mclk = 1'b0;
		forever #10 i_mclk = ~i_mclk;
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Run is far shorter than this; reaching it means a hang
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 40000) begin
			bad_count++;
			stop_test();
		end
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic logic [1:0] sup_exp(input logic en, keep, fp, aut,
		deep);
		if (!en) return UNIT_OFF;
		if (!deep) return fp ? UNIT_FULL : UNIT_NORMAL;
		if (!aut) return keep ? (fp ? UNIT_FULL : UNIT_NORMAL) : UNIT_OFF;
		return (keep && fp) ? UNIT_NORMAL : UNIT_OFF;
	endfunction

	// High monitor under automatic control is fully off in deep sleep
	function automatic logic [1:0] mon_exp(input logic en, fp, aut, deep, hi);
		if (!en) return UNIT_OFF;
		if (!deep || !aut) return fp ? UNIT_FULL : UNIT_NORMAL;
		if (hi) return UNIT_OFF;
		return fp ? UNIT_NORMAL : UNIT_OFF;
	endfunction

	// Write pulse, then count cycles until the pending flag drops
	task automatic settle(input logic hi, input int n);
		int c;
		@(negedge i_mclk);
		if (hi) hw = 1'b1;
		else lw = 1'b1;
		@(negedge i_mclk);
		{hw, lw} = 2'b00;
		check(hi ? o_hpend : o_lpend, 1'b1);
		c = 0;
		while ((hi ? o_hpend : o_lpend) === 1'b1 && c < 9000) begin
			@(negedge i_mclk);
			c++;
		end
		check(c >= n - 1 && c <= n + 1, 1'b1);
	endtask

	task automatic trip(input logic [2:0] t);
		seen = 2'b00;
		@(negedge i_mclk);
		{hmt, lmt, lst} = t;
		@(negedge i_mclk);
		{hmt, lmt, lst} = 3'b000;
		repeat (3) begin
			seen = seen | {o_por, o_irq};
			@(negedge i_mclk);
		end
	endtask

	task automatic wait_clear();
		int c;
		c = 0;
		while ((o_lpend | o_hpend) !== 1'b0 && c < 9000) begin
			@(negedge i_mclk);
			c++;
		end
	endtask

	initial begin
		{i_resetn, i_soft_reset, i_sub_clk_from_osc, i_wake_irq} = 4'h0;
		i_pmode = 2'h0;
		{lw, lse, lsk, lsf, lme, lmf, la} = 7'h00;
		{hw, hse, hsk, hsf, hme, hmf, ha, overvoltage_guard} = 8'h00;
		{lst, lmt, hmt, psel} = 4'h0;
		repeat (5) @(negedge i_mclk);
		check({o_ls, o_lm, o_hs, o_hm, o_lpend, o_hpend, o_por, o_gate},
			16'h0001);
		i_resetn = 1'b1;
		$display("test reset done");

		for (int m = 0; m < 3; m++) begin
			for (int v = 0; v < 64; v++) begin
				@(negedge i_mclk);
				{lse, lsk, lsf, lme, lmf, la} = v[5:0];
				{hse, hsk, hsf, hme, hmf, ha} = v[5:0];
				i_pmode = m[1:0];
				i_sub_clk_from_osc = v[0] ^ m[0];
				@(negedge i_mclk);
				check(o_ls, sup_exp(lse, lsk, lsf, la, m == 2));
				check(o_lm, mon_exp(lme, lmf, la, m == 2, 0));
				check(o_hs, sup_exp(hse, hsk, hsf, ha, m == 2));
				check(o_hm, mon_exp(hme, hmf, ha, m == 2, 1));
				check(o_slow, (lse & !lsf) | (lme & !lmf));
				check(o_gate, 1'b1);
			end
		end
		$display("test decode done");

		i_pmode = 2'h0;
		{lse, lsk, lsf, lme, lmf, la} = 6'b101110;
		{hse, hsk, hsf, hme, hmf, ha} = 6'b111110;
		settle(1'b0, 100);
		settle(1'b1, 100);
		lsf = 1'b0;
		settle(1'b0, 7500);
		check(o_slow, 1'b1);
		lsf = 1'b1;
		wait_clear();
		$display("test settle done");

		psel = 1'b1;
		@(negedge i_mclk);
		lw = 1'b1;
		@(negedge i_mclk);
		lw = 1'b0;
		trip(3'b001);
		check(seen, 2'b00);
		wait_clear();
		for (int s = 0; s < 2; s++) begin
			psel = s[0];
			trip(3'b001);
			check(seen, {psel, !psel});
			trip(3'b010);
			check(seen, {psel, !psel});
		end
		overvoltage_guard = 1'b1;
		trip(3'b100);
		check(seen[1], 1'b1);
		overvoltage_guard = 1'b0;
		trip(3'b100);
		check(seen[1], 1'b0);
		$display("test trip done");

		// Deep entry right after a write, interrupt already pending
		{hsk, hsf, hme} = 3'b000;
		@(negedge i_mclk);
		lw = 1'b1;
		@(negedge i_mclk);
		lw = 1'b0;
		i_pmode = 2'h2;
		i_wake_irq = 1'b1;
		repeat (4) @(negedge i_mclk);
		check(o_wake, 1'b0);
		i_soft_reset = 1'b1;
		repeat (2) @(negedge i_mclk);
		i_soft_reset = 1'b0;
		repeat (2) @(negedge i_mclk);
		check(o_wake, 1'b1);
		i_pmode = 2'h0;
		@(negedge i_mclk);
		check(o_wake, 1'b0);
		i_wake_irq = 1'b0;
		check(o_gate, 1'b1);
		repeat (100) @(negedge i_mclk);
		$display("test wake done");
		stop_test();
	end
endmodule // sss_supply_supervisor_tb_top
